/* timer_map.vh */
// Purpose: register offsets, field positions and reset values of the
//          dual channel timer core
// Assumes: 5-bit register index, 16-bit register data
// Notes:   channel registers sit in banks of eight, one bank per channel
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

// ------------------------------------------------------------------
// common registers
// ------------------------------------------------------------------
`define RUN_ADDR      5'h00
`define MODE_ADDR     5'h01
`define PWM_ADDR      5'h02
`define FUNC_ADDR     5'h03
`define OUTDIS_ADDR   5'h04
`define KILL_ADDR     5'h05
`define OUTINIT_ADDR  5'h06

// ------------------------------------------------------------------
// channel banks: bank in index bits 4:3, register in bits 2:0
// ------------------------------------------------------------------
`define CH0_BANK      2'h1
`define CH1_BANK      2'h2
`define SUB_CTRL      3'h0
`define SUB_IO        3'h1
`define SUB_CNT       3'h2
`define SUB_GR_FIRST  3'h3

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define RUN_CH0_BIT   0
`define RUN_CH1_BIT   1
`define STOP_CH0_BIT  2
`define STOP_CH1_BIT  3
`define MODE_SYNC_BIT 0
`define FUNC_SPAIR_N  7
`define FUNC_EXTCLK   6
`define FUNC_ADEG     5
`define FUNC_ADTRG    4
`define FUNC_OLS1     3
`define FUNC_OLS0     2
`define KILL_MODE_BIT 7

// ------------------------------------------------------------------
// reset values and fixed read values
// ------------------------------------------------------------------
`define RUN_RESERVED  4'hF
`define STOP_RST      2'h3
`define RUN_RST       2'h0
`define FUNC_RST      8'h80
`define OUTDIS_RST    8'hFF
`define KILL_RESERVED 7'h7F
`define PWM_RESERVED  8'h11

// combination modes
`define CMB_NORMAL    2'h0
`define CMB_RESET_PWM 2'h1

`endif

/* timer_channel.v */
// Purpose: one timer channel, counter plus four general registers
// Assumes: pins synchronous to clk_sys_i, tick_i one cycle per count
// Notes:   compare match fires as the counter leaves the matching value
`include "timer_map.vh"

module timer_channel #(
   parameter W = 16
) (
   input  wire         clk_sys_i,
   input  wire         resetn_i,
   input  wire         tick_i,
   input  wire         down_i,
   input  wire         wr_cnt_i,
   input  wire [3:0]   wr_gr_i,
   input  wire [W-1:0] wdata_i,
   input  wire [15:0]  io_ctrl_i,
   input  wire [2:0]   clr_sel_i,
   input  wire         buf_c_i,
   input  wire         buf_d_i,
   input  wire [3:0]   pin_i,
   input  wire         peer_clear_i,
   output wire [W-1:0] cnt_o,
   output wire [4*W-1:0] gr_o,
   output wire [3:0]   match_o,
   output wire [3:0]   capture_o,
   output wire         clear_req_o,
   output wire         ovf_o,
   output wire         unf_o
);

   reg  [W-1:0] cnt_reg;
   reg  [W-1:0] gr_reg [0:3];
   reg  [3:0]   pin_prev_reg;
   wire [3:0]   event_w;
   wire         clear_w;
   integer      i;

   // ---------------------------------------------------------------
   // compare and capture detection
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gen_gr
         wire [1:0] sel = io_ctrl_i[4*g+1:4*g];
         wire       cap = io_ctrl_i[4*g+3];
         assign match_o[g]   = tick_i & ~cap & (cnt_reg == gr_reg[g]);
         // edge select: bit 0 rising, bit 1 falling, both for both edges
         assign capture_o[g] = cap &
            ((sel[0] & pin_i[g] & ~pin_prev_reg[g]) |
             (sel[1] & ~pin_i[g] & pin_prev_reg[g]));
         assign gr_o[W*g +: W] = gr_reg[g];
      end
   endgenerate

   assign event_w     = match_o | capture_o;
   assign clear_req_o = (clr_sel_i >= 3'h1) & (clr_sel_i <= 3'h4) &
                        event_w[clr_sel_i[1:0] - 2'h1];
   assign clear_w     = clear_req_o | peer_clear_i;
   assign ovf_o = tick_i & ~down_i & (&cnt_reg) & ~clear_w;
   assign unf_o = tick_i & down_i & (cnt_reg == {W{1'b0}});
   assign cnt_o = cnt_reg;

   // ---------------------------------------------------------------
   // counter: clear beats write, write beats count
   // ---------------------------------------------------------------
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_reg      <= {W{1'b0}};
         pin_prev_reg <= 4'h0;
      end else begin
         pin_prev_reg <= pin_i;
         if (clear_w)
            cnt_reg <= {W{1'b0}};
         else if (wr_cnt_i)
            cnt_reg <= wdata_i;
         else if (tick_i && down_i)
            cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
         else if (tick_i)
            cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      end
   end

   // ---------------------------------------------------------------
   // general registers with optional buffering through C and D
   // ---------------------------------------------------------------
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (i = 0; i < 4; i = i + 1)
            gr_reg[i] <= {W{1'b1}};
      end else begin
         for (i = 0; i < 4; i = i + 1) begin
            if (capture_o[i])
               gr_reg[i] <= cnt_reg;
            else if (wr_gr_i[i])
               gr_reg[i] <= wdata_i;
         end
         // old capture moves on to the buffer, compare reloads from it
         if (buf_c_i && capture_o[0])
            gr_reg[2] <= gr_reg[0];
         if (buf_c_i && match_o[0])
            gr_reg[0] <= gr_reg[2];
         if (buf_d_i && capture_o[1])
            gr_reg[3] <= gr_reg[1];
         if (buf_d_i && match_o[1])
            gr_reg[1] <= gr_reg[3];
      end
   end

endmodule // timer_channel

/* dual_channel_timer_core.v */
// Purpose: two channel 16-bit timer unit with compare, capture and PWM
// Assumes: register port and pins synchronous to clk_sys_i
// Notes:   register reads return data one cycle after the index
`include "timer_map.vh"

module dual_channel_timer_core #(
   parameter W = 16
) (
   input  wire         clk_sys_i,
   input  wire         resetn_i,
   input  wire         reg_wr_i,
   input  wire [4:0]   reg_addr_i,
   input  wire [15:0]  reg_wdata_i,
   input  wire [7:0]   timer_pin_i,
   input  wire         fast_oscillator_clock_i,
   input  wire         output_kill_input_n_i,
   output reg  [15:0]  reg_rdata_o,
   output reg  [7:0]   timer_pin_o,
   output reg  [7:0]   timer_pin_oe_n_o,
   output reg  [10:0]  irq_source_o,
   output reg          adc_trigger_o
);

   // ---------------------------------------------------------------
   // control state
   // ---------------------------------------------------------------
   reg  [1:0]   run_reg, stop_reg;
   reg  [7:0]   mode_reg, pwm_reg, func_reg, init_reg;
   reg  [7:0]   outdis_reg, outdis_next, level_next;
   reg          kill_mode_reg, fosc_prev_reg, ext_prev_reg;
   reg  [5:0]   ctl0_reg, ctl1_reg;
   reg  [15:0]  io0_reg, io1_reg, rdata_next;
   reg  [4:0]   pre_reg;
   reg  [2:0]   pend_reg, pend_next;
   integer      p, k, ch;

   wire [1:0]   bank = reg_addr_i[4:3];
   wire [2:0]   sub  = reg_addr_i[2:0];
   wire         wr_ch0 = reg_wr_i & (bank == `CH0_BANK);
   wire         wr_ch1 = reg_wr_i & (bank == `CH1_BANK);
   wire         wr_run = reg_wr_i & (reg_addr_i == `RUN_ADDR);
   wire         sync   = mode_reg[`MODE_SYNC_BIT];
   wire         spair  = ~func_reg[`FUNC_SPAIR_N];
   wire [1:0]   cmb    = func_reg[1:0];
   wire         ols0   = func_reg[`FUNC_OLS0];
   wire         ols1   = func_reg[`FUNC_OLS1];
   wire [31:0]  io_all = {io1_reg, io0_reg};

   // ---------------------------------------------------------------
   // count clock sources
   // ---------------------------------------------------------------
   wire fosc_rise = fast_oscillator_clock_i & ~fosc_prev_reg;
   wire ext_rise  = func_reg[`FUNC_EXTCLK] & timer_pin_i[0] &
                    ~ext_prev_reg;

   // prescaler taps: one-cycle enables, no gated clocks
   function clk_edge;
      input [2:0] s;
      begin
         case (s)
            3'h0:    clk_edge = 1'b1;
            3'h1:    clk_edge = pre_reg[0];
            3'h2:    clk_edge = &pre_reg[1:0];
            3'h3:    clk_edge = &pre_reg[2:0];
            3'h4:    clk_edge = &pre_reg;
            3'h5:    clk_edge = fosc_rise;
            3'h6:    clk_edge = ext_rise;
            default: clk_edge = 1'b0;
         endcase
      end
   endfunction

   wire tick0 = run_reg[0] & clk_edge(ctl0_reg[5:3]);
   wire tick1 = run_reg[1] & clk_edge(ctl1_reg[5:3]);

   // ---------------------------------------------------------------
   // channels
   // ---------------------------------------------------------------
   wire [W-1:0]   cnt0, cnt1;
   wire [4*W-1:0] gr0, gr1;
   wire [3:0]     m0, m1, c0, c1;
   wire           clr0, clr1, ovf0, ovf1, unf1;
   wire           wr_cnt_any = (wr_ch0 | wr_ch1) & (sub == `SUB_CNT);
   wire [7:0]     match = {m1, m0};

   timer_channel #(.W(W)) u_ch0 (
      .clk_sys_i    (clk_sys_i),
      .resetn_i     (resetn_i),
      .tick_i       (tick0),
      .down_i       (1'b0),
      .wr_cnt_i     (sync ? wr_cnt_any : wr_ch0 & (sub == `SUB_CNT)),
      .wr_gr_i      ({4{wr_ch0}} & (4'h1 << (sub - `SUB_GR_FIRST)) &
                     {4{sub >= `SUB_GR_FIRST}}),
      .wdata_i      (reg_wdata_i[W-1:0]),
      .io_ctrl_i    (io0_reg),
      .clr_sel_i    (ctl0_reg[2:0]),
      .buf_c_i      (mode_reg[4]),
      .buf_d_i      (mode_reg[5]),
      .pin_i        (timer_pin_i[3:0]),
      .peer_clear_i (sync & clr1),
      .cnt_o        (cnt0),
      .gr_o         (gr0),
      .match_o      (m0),
      .capture_o    (c0),
      .clear_req_o  (clr0),
      .ovf_o        (ovf0),
      .unf_o        ()
   );

   // complementary mode runs channel 1 downward for the underflow
   timer_channel #(.W(W)) u_ch1 (
      .clk_sys_i    (clk_sys_i),
      .resetn_i     (resetn_i),
      .tick_i       (tick1),
      .down_i       (cmb[1]),
      .wr_cnt_i     (sync ? wr_cnt_any : wr_ch1 & (sub == `SUB_CNT)),
      .wr_gr_i      ({4{wr_ch1}} & (4'h1 << (sub - `SUB_GR_FIRST)) &
                     {4{sub >= `SUB_GR_FIRST}}),
      .wdata_i      (reg_wdata_i[W-1:0]),
      .io_ctrl_i    (io1_reg),
      .clr_sel_i    (ctl1_reg[2:0]),
      .buf_c_i      (mode_reg[6]),
      .buf_d_i      (mode_reg[7]),
      .pin_i        (timer_pin_i[7:4]),
      .peer_clear_i (sync & clr0),
      .cnt_o        (cnt1),
      .gr_o         (gr1),
      .match_o      (m1),
      .capture_o    (c1),
      .clear_req_o  (clr1),
      .ovf_o        (ovf1),
      .unf_o        (unf1)
   );

   // ---------------------------------------------------------------
   // pin levels per operating mode
   // ---------------------------------------------------------------
   always @* begin
      level_next = timer_pin_o;
      pend_next  = pend_reg;
      if (reg_wr_i && reg_addr_i == `OUTINIT_ADDR)
         level_next = reg_wdata_i[7:0];
      if (cmb != `CMB_NORMAL) begin
         // phases on B0, A1, B1; counter phases on D0, C1, D1
         if (m0[0]) begin
            level_next[2] = ~timer_pin_o[2];
            level_next[1] = ols0;
            level_next[4] = ols0;
            level_next[5] = ols0;
            level_next[3] = ~ols1;
            level_next[6] = ~ols1;
            level_next[7] = ~ols1;
            pend_next = 3'h0;
         end
         for (k = 0; k < 3; k = k + 1) begin
            if (match[(k == 0) ? 1 : k + 3] && !m0[0]) begin
               level_next[(k == 0) ? 1 : k + 3] = ~ols0;
               if (cmb[1])
                  pend_next[k] = 1'b1;
               else
                  level_next[(k == 0) ? 3 : k + 5] = ols1;
            end else if (pend_reg[k] && tick0 && !m0[0]) begin
               // one count of dead time before the counter phase
               level_next[(k == 0) ? 3 : k + 5] = ols1;
               pend_next[k] = 1'b0;
            end
         end
      end else if (spair) begin
         if (m0[0])
            level_next[1] = init_reg[1];
         else if (m1[0])
            level_next[1] = ~init_reg[1];
         level_next[5] = ~level_next[1];
      end else begin
         for (p = 0; p < 8; p = p + 1) begin
            if (pwm_reg[p] && match[p])
               level_next[p] = ~init_reg[p];
            else if (pwm_reg[p] && match[p & 4])
               level_next[p] = init_reg[p];
            else if (match[p] && !pwm_reg[p]) begin
               case (io_all[4*p +: 2])
                  2'h1:    level_next[p] = 1'b0;
                  2'h2:    level_next[p] = 1'b1;
                  2'h3:    level_next[p] = ~timer_pin_o[p];
                  default: level_next[p] = timer_pin_o[p];
               endcase
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // output disable: the kill input beats a software clear
   // ---------------------------------------------------------------
   always @* begin
      outdis_next = outdis_reg;
      if (reg_wr_i && reg_addr_i == `OUTDIS_ADDR)
         outdis_next = reg_wdata_i[7:0];
      if (kill_mode_reg && !output_kill_input_n_i)
         outdis_next = 8'hFF;
   end

   // ---------------------------------------------------------------
   // register read data
   // ---------------------------------------------------------------
   always @* begin
      rdata_next = 16'h0000;
      case (reg_addr_i)
         `RUN_ADDR:     rdata_next[7:0] = {`RUN_RESERVED, stop_reg,
                                           run_reg};
         `MODE_ADDR:    rdata_next[7:0] = mode_reg;
         `PWM_ADDR:     rdata_next[7:0] = pwm_reg | `PWM_RESERVED;
         `FUNC_ADDR:    rdata_next[7:0] = func_reg;
         `OUTDIS_ADDR:  rdata_next[7:0] = outdis_reg;
         `KILL_ADDR:    rdata_next[7:0] = {kill_mode_reg,
                                           `KILL_RESERVED};
         `OUTINIT_ADDR: rdata_next[7:0] = timer_pin_o;
         default: begin
            if (bank == `CH0_BANK || bank == `CH1_BANK) begin
               case (sub)
                  `SUB_CTRL: rdata_next[5:0] = bank[0] ? ctl0_reg
                                                       : ctl1_reg;
                  `SUB_IO:   rdata_next = bank[0] ? io0_reg : io1_reg;
                  `SUB_CNT:  rdata_next = bank[0] ? cnt0 : cnt1;
                  default:   rdata_next = (sub == 3'h7) ? 16'h0000 :
                     bank[0] ? gr0[W*(sub - `SUB_GR_FIRST) +: W] :
                     gr1[W*(sub - `SUB_GR_FIRST) +: W];
               endcase
            end
         end
      endcase
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         run_reg          <= `RUN_RST;
         stop_reg         <= `STOP_RST;
         mode_reg         <= 8'h00;
         pwm_reg          <= 8'h00;
         func_reg         <= `FUNC_RST;
         outdis_reg       <= `OUTDIS_RST;
         kill_mode_reg    <= 1'b0;
         init_reg         <= 8'h00;
         ctl0_reg         <= 6'h00;
         ctl1_reg         <= 6'h00;
         io0_reg          <= 16'h0000;
         io1_reg          <= 16'h0000;
         pre_reg          <= 5'h00;
         fosc_prev_reg    <= 1'b0;
         ext_prev_reg     <= 1'b0;
         pend_reg         <= 3'h0;
         reg_rdata_o      <= 16'h0000;
         timer_pin_o      <= 8'h00;
         timer_pin_oe_n_o <= 8'hFF;
         irq_source_o     <= 11'h000;
         adc_trigger_o    <= 1'b0;
      end else begin
         pre_reg       <= pre_reg + 5'h01;
         fosc_prev_reg <= fast_oscillator_clock_i;
         ext_prev_reg  <= timer_pin_i[0];
         pend_reg      <= pend_next;
         outdis_reg    <= outdis_next;
         timer_pin_o   <= level_next;
         reg_rdata_o   <= rdata_next;
         // driven only where enabled and not a capture input
         timer_pin_oe_n_o <= outdis_next |
            {io1_reg[15], io1_reg[11], io1_reg[7], io1_reg[3],
             io0_reg[15], io0_reg[11], io0_reg[7],
             io0_reg[3] | func_reg[`FUNC_EXTCLK]};
         irq_source_o  <= {unf1, ovf1, m1 | c1, ovf0, m0 | c0};
         adc_trigger_o <= cmb[1] & func_reg[`FUNC_ADTRG] &
            (func_reg[`FUNC_ADEG] ? unf1 : m0[0]);
         if (wr_run)
            stop_reg <= reg_wdata_i[3:2];
         for (ch = 0; ch < 2; ch = ch + 1) begin
            if (wr_run && reg_wdata_i[ch])
               run_reg[ch] <= 1'b1;
            else if (wr_run && stop_reg[ch])
               run_reg[ch] <= 1'b0;
            else if (match[4*ch] && !stop_reg[ch])
               run_reg[ch] <= 1'b0;
         end
         if (reg_wr_i) begin
            case (reg_addr_i)
               `MODE_ADDR: mode_reg  <= reg_wdata_i[7:0];
               `PWM_ADDR:  pwm_reg   <= reg_wdata_i[7:0] &
                                        ~`PWM_RESERVED;
               `FUNC_ADDR: func_reg  <= reg_wdata_i[7:0];
               `KILL_ADDR: kill_mode_reg <=
                              reg_wdata_i[`KILL_MODE_BIT];
               `OUTINIT_ADDR: init_reg <= reg_wdata_i[7:0];
               default: begin
                  if (wr_ch0 && sub == `SUB_CTRL)
                     ctl0_reg <= reg_wdata_i[5:0];
                  if (wr_ch1 && sub == `SUB_CTRL)
                     ctl1_reg <= reg_wdata_i[5:0];
                  if (wr_ch0 && sub == `SUB_IO)
                     io0_reg <= reg_wdata_i;
                  if (wr_ch1 && sub == `SUB_IO)
                     io1_reg <= reg_wdata_i;
               end
            endcase
         end
      end
   end

endmodule // dual_channel_timer_core

/* pin_partner.sv */
// Purpose: far-side circuitry on the eight timer pins
// Assumes: oe_n low means the core drives the pin
// Notes:   undriven pins follow drv_i so captures see real edges
module pin_partner (
   input  wire logic [7:0] pin_o_i,
   input  wire logic [7:0] oe_n_i,
   input  wire logic [7:0] drv_i,
   output logic      [7:0] pin_i_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // wire level from both parties, core wins where it drives
   assign pin_i_o = (~oe_n_i & pin_o_i) | (oe_n_i & drv_i);
endmodule // pin_partner

/* dual_channel_timer_core_assertions.sv */
// Purpose: port checks of the timer core
// Assumes: reads answer one cycle after the index
// Notes:   ok_reg masks the first edge after reset
module dual_channel_timer_core_assertions (
   input wire logic        clk_sys_i,
   input wire logic        resetn_i,
   input wire logic        reg_wr_i,
   input wire logic [4:0]  reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic        output_kill_input_n_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic [7:0]  timer_pin_oe_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic ok_reg;
   logic kill_reg;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ok_reg   <= 1'b0;
         kill_reg <= 1'b0;
      end else begin
         ok_reg <= 1'b1;
         if (reg_wr_i && reg_addr_i == 5'h05)
            kill_reg <= reg_wdata_i[7];
      end
   end
   a_run_upper_ones: assert property (
      ok_reg && $past(reg_addr_i) == 5'h00 |-> reg_rdata_o[7:4] == 4'hF)
      else $error("run upper bits");
   a_high_byte_zero: assert property (ok_reg && $past(reg_addr_i) == 5'h00
      |-> reg_rdata_o[15:8] == 8'h00) else $error("high byte");
   a_unmapped_zero: assert property (ok_reg && $past(reg_addr_i) == 5'h07
      |-> reg_rdata_o == 16'h0000) else $error("unmapped read");
   a_kill_reg_ones: assert property (ok_reg && $past(reg_addr_i) == 5'h05
      |-> reg_rdata_o[6:0] == 7'h7F) else $error("kill reg bits");
   a_pwm_reserved: assert property (ok_reg && $past(reg_addr_i) == 5'h02
      |-> reg_rdata_o[0] && reg_rdata_o[4]) else $error("pwm reserved");
   a_kill_outputs: assert property (
      kill_reg && !output_kill_input_n_i
      |-> ##[1:2] timer_pin_oe_n_o == 8'hFF) else $error("kill ignored");
   a_run_sets: assert property (reg_wr_i && reg_addr_i == 5'h00 &&
      reg_wdata_i[2:0] == 3'h5 ##1 !reg_wr_i && reg_addr_i == 5'h00
      |=> reg_rdata_o[0]) else $error("run not set");
   a_run_clears: assert property (reg_wr_i && reg_addr_i == 5'h00 &&
      reg_wdata_i[2] && !reg_wdata_i[0] ##1 !reg_wr_i && reg_addr_i == 5'h00
      |=> !reg_rdata_o[0]) else $error("run not cleared");
   a_stop_bits_rw: assert property (reg_wr_i && reg_addr_i == 5'h00
      ##1 !reg_wr_i && reg_addr_i == 5'h00
      |=> reg_rdata_o[3:2] == $past(reg_wdata_i[3:2], 2))
      else $error("stop bits");
endmodule // dual_channel_timer_core_assertions
bind dual_channel_timer_core dual_channel_timer_core_assertions u_chk (
   .clk_sys_i, .resetn_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
   .output_kill_input_n_i, .reg_rdata_o, .timer_pin_oe_n_o);

/* tb_dual_channel_timer_core.sv */
// Purpose: self-checking bench of the timer core
// Assumes: inputs change on the falling edge
// Notes:   counts run on the undivided clock to keep the run short
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_dual_channel_timer_core;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys_i = 0, resetn_i = 0, reg_wr_i = 0, kill_n = 1;
   logic        fosc = 0, adc, p;
   logic [4:0]  reg_addr_i = 0;
   logic [15:0] reg_wdata_i = 0, rdata, r, d;
   logic [7:0]  drv = 0, pin_i, pin_o, oe_n;
   logic [10:0] irq;
   logic [4:0]  ta [7] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h0B};
   logic [15:0] te [7] = '{16'h00FC, 16'h0011, 16'h0080, 16'h00FF,
                           16'h007F, 16'h0000, 16'hFFFF};
   int          n_errors = 0, compares = 0, seed = 40, n, g;
   dual_channel_timer_core dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .timer_pin_i(pin_i), .fast_oscillator_clock_i(fosc),
      .output_kill_input_n_i(kill_n), .reg_rdata_o(rdata),
      .timer_pin_o(pin_o), .timer_pin_oe_n_o(oe_n), .irq_source_o(irq),
      .adc_trigger_o(adc));
   pin_partner u_pins (.pin_o_i(pin_o), .oe_n_i(oe_n), .drv_i(drv),
      .pin_i_o(pin_i));
   initial begin
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   always @(negedge clk_sys_i) fosc <= ~fosc;
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(negedge clk_sys_i);
      reg_wr_i = 1;
      reg_addr_i = a;
      reg_wdata_i = v;
      @(negedge clk_sys_i);
      reg_wr_i = 0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] v);
      @(negedge clk_sys_i);
      reg_addr_i = a;
      @(negedge clk_sys_i);
      v = rdata;
   endtask
   // bounded wait; the count is the spacing in cycles
   task automatic wait_irq(input int b, input int lim, output int c);
      c = 0;
      do begin
         @(negedge clk_sys_i);
         c++;
      end while (irq[b] !== 1'b1 && c < lim);
      if (irq[b] !== 1'b1) begin
         n_errors++;
         end_sim();
      end
   endtask
   task automatic end_sim();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (5) @(negedge clk_sys_i);
      resetn_i = 1;
      for (int i = 0; i < 7; i++) begin
         rd(ta[i], d);
         `CHK(d, te[i])
      end
      $display("reset values done");
      wr(5'h00, 16'h000D);
      rd(5'h00, d);
      `CHK(d, 16'h00FD)
      rd(5'h0A, r);
      rd(5'h0A, d);
      `CHK(d - r, 16'h0002)
      wr(5'h00, 16'h000C);
      rd(5'h00, d);
      `CHK(d, 16'h00FC)
      $display("run control done");
      g = 3 + {$random(seed)} % 8;
      wr(5'h0A, 16'h0000);
      wr(5'h08, 16'h0001);
      wr(5'h09, 16'h0003);
      wr(5'h0B, g[15:0]);
      wr(5'h06, 16'h0000);
      wr(5'h04, 16'h00FE);
      wr(5'h00, 16'h0009);
      wait_irq(0, 40, n);
      `CHK(pin_o[0], 1'b1)
      rd(5'h00, d);
      `CHK(d, 16'h00F8)
      rd(5'h0A, d);
      `CHK(d, 16'h0000)
      wr(5'h00, 16'h000A);
      rd(5'h0A, d);
      `CHK(d, 16'h0000)
      rd(5'h12, d);
      `CHK(d == 16'h0000, 1'b0)
      wr(5'h00, 16'h000D);
      wait_irq(0, 40, n);
      p = pin_o[0];
      wait_irq(0, 40, n);
      `CHK(n, g + 1)
      `CHK(pin_o[0], ~p)
      $display("compare match done");
      wr(5'h00, 16'h000C);
      wr(5'h08, 16'h0000);
      wr(5'h0A, 16'hFFFE);
      wr(5'h00, 16'h000D);
      wait_irq(4, 8, n);
      rd(5'h0A, d);
      `CHK(d < 16'h0008, 1'b1)
      $display("overflow done");
      `CHK(oe_n[0], 1'b0)
      wr(5'h05, 16'h0080);
      @(negedge clk_sys_i);
      kill_n = 0;
      @(negedge clk_sys_i);
      kill_n = 1;
      @(negedge clk_sys_i);
      `CHK(oe_n, 8'hFF)
      rd(5'h04, d);
      `CHK(d, 16'h00FF)
      $display("output kill done");
      wr(5'h00, 16'h000C);
      r = 16'($random(seed));
      wr(5'h10, 16'h0000);
      wr(5'h11, 16'h0009);
      wr(5'h12, r);
      @(negedge clk_sys_i);
      drv[4] = 1;
      wait_irq(5, 5, n);
      rd(5'h13, d);
      `CHK(d, r)
      @(negedge clk_sys_i);
      drv[4] = 0;
      g = 0;
      repeat (4) begin
         @(negedge clk_sys_i);
         g += irq[5];
      end
      `CHK(g, 0)
      $display("capture done");
      // both counters idle, so a synchronous write must reach channel 1
      wr(5'h01, 16'h0001);
      wr(5'h0A, 16'h0040);
      rd(5'h12, d);
      `CHK(d, 16'h0040)
      wr(5'h01, 16'h0000);
      $display("sync write done");
      wr(5'h0A, 16'h0000);
      wr(5'h08, 16'h0001);
      wr(5'h03, 16'h0092);
      wr(5'h00, 16'h000D);
      wait_irq(0, 40, n);
      `CHK(adc, 1'b1)
      `CHK(pin_o[3], 1'b1)
      $display("complementary done");
      end_sim();
   end
endmodule // tb_dual_channel_timer_core
